/* fc_tx_pkg.sv */
package fc_tx_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] TXDATA_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  // control field positions
  localparam int RATE_BIT  = 0;
  localparam int ALT_BIT   = 1;
  localparam int COMMA_BIT = 2;
  localparam int WRAP_BIT  = 3;
  localparam int ROUTEB_BIT = 4;
  localparam int ROUTEA_BIT = 5;
  localparam int CTRL_W    = 6;
  // control reset: low rate, no alternation, comma off, route code 0
  localparam logic [5:0] CTRL_RST = 6'h04;
  // status field positions
  localparam int COUNT_LSB  = 0;
  localparam int EMPTY_BIT  = 8;
  localparam int FULL_BIT   = 9;
  // character geometry
  localparam int LANE_W = 10;
  localparam int WORD_W = 20;
  localparam int FIFO_DEPTH = 32;
  // comma, a..j = 0011111010, bit a in bit 0
  localparam logic [9:0] K28_5_POS = 10'h17c;
  // byte period in pclk cycles, half period for lane 1 capture
  localparam logic [4:0] BYTE_CYCLES = 5'h14;
  localparam logic [4:0] HALF_CYCLES = 5'h0a;
  // route codes
  localparam logic [2:0] ROUTE_SI_LASER = 3'h6;
  localparam logic [2:0] ROUTE_SI_LOOP  = 3'h7;
endpackage

/* fc_tx_serializer_front_end.sv */
// What this block does
// - rate select low: 531.25 Mbaud mode, only byte lane 0 sent.
// - rate select high: 1062.5 Mbaud mode, both byte lanes sent.
// - no line encoding applied; sender supplies 8B/10B characters.
// - from reset every transmit timing derives from the internal generator.
// - low rate: one lane 0 character captured each byte clock rising edge.
// - high rate, alternation off: both lanes captured together each edge.
// - high rate, alternation on: one byte captured per half byte clock.
// - alternation: lane 0 at rising edge, lane 1 half a cycle later.
// - comma force low: lane 0 data dropped, K28.5 sent instead.
// - forced comma is always the positive disparity form 0011111010.
// - latched 10 or 20 bits shift out serially straight to routing.
// - route a, route b, wrap form a 3-bit code choosing outputs.
// - code 0 laser only; code 1 loopback only; internal stream.
// - code 2 cable and laser; code 3 cable and loopback; internal.
// - code 4 cable only; code 5 laser and loopback; internal.
// - codes 6, 7: cable internal, external input on laser or loopback.
`timescale 1ns/10ps

module fc_tx_fifo #(
  parameter int W = 20,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // fill side
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  // drain side
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  // fill level
  output logic [$clog2(D):0]          count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  // honest flags
  assign in_ready  = (cnt_q != (AW + 1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;

  // storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

module fc_tx_serializer_front_end
  import fc_tx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // external serial input
  input  wire logic        ext_serial_in,
  // serial outputs
  output logic             cable_serial_out,
  output logic             laser_serial_out,
  output logic             loopback_serial_out,
  // output enables
  output logic             cable_enable,
  output logic             laser_enable,
  output logic             loopback_enable
);
  // routing table: {cable, laser, loopback} enables per code
  function automatic logic [2:0] route_enables(input logic [2:0] code);
    unique case (code)
      3'h0: route_enables = 3'b010;
      3'h1: route_enables = 3'b001;
      3'h2: route_enables = 3'b110;
      3'h3: route_enables = 3'b101;
      3'h4: route_enables = 3'b100;
      3'h5: route_enables = 3'b011;
      3'h6: route_enables = 3'b110;
      3'h7: route_enables = 3'b101;
    endcase
  endfunction

  logic [CTRL_W-1:0]     ctrl_q;
  logic [31:0]           prdata_q;
  logic [4:0]            div_q;
  logic [LANE_W-1:0]     lane0_q;
  logic [LANE_W-1:0]     lane1_q;
  logic                  alt_take_q;
  logic [WORD_W-1:0]     shift_q;
  logic                  cable_q;
  logic                  laser_q;
  logic                  loop_q;
  logic [2:0]            en_q;
  logic                  fifo_in_ready;
  logic                  fifo_valid;
  logic [WORD_W-1:0]     fifo_data;
  logic [$clog2(DEPTH):0] fifo_count;

  // control fields
  wire       rate_select       = ctrl_q[RATE_BIT];
  wire       alternating_capture_select = ctrl_q[ALT_BIT];
  wire       comma_force_n     = ctrl_q[COMMA_BIT];
  wire [2:0] route_code        = {ctrl_q[ROUTEA_BIT], ctrl_q[ROUTEB_BIT],
                                  ctrl_q[WRAP_BIT]};
  wire       alt_mode          = rate_select && alternating_capture_select;

  // apb decode
  wire       setup_ok  = psel && penable;
  wire       hit_ctrl  = (paddr == CTRL_OFF);
  wire       hit_data  = (paddr == TXDATA_OFF);
  wire       hit_stat  = (paddr == STATUS_OFF);
  wire       data_wr   = setup_ok && pwrite && hit_data;
  wire       push      = data_wr && fifo_in_ready;
  wire       ctrl_wr   = setup_ok && pwrite && hit_ctrl && pready;

  // a data write waits while the fifo is full
  assign pready  = !(data_wr && !fifo_in_ready);
  assign pslverr = setup_ok && !(hit_ctrl || hit_data || hit_stat);

  // read mux, sampled in the setup cycle so read data leaves a flop
  wire [31:0] stat_word = {22'h0, !fifo_in_ready, !fifo_valid, 2'h0,
                           6'(fifo_count)};
  wire        rd_setup  = psel && !penable && !pwrite;
  wire [31:0] rd_word   = hit_ctrl ? {26'h0, ctrl_q} :
                          hit_stat ? stat_word : 32'h0;

  // held through the access phase, cleared once the bus moves on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (rd_setup) begin
      prdata_q <= rd_word;
    end else if (!setup_ok) begin
      prdata_q <= 32'h0;
    end
  end

  assign prdata = prdata_q;

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  // byte clock generator, all transmit timing from here
  wire byte_tick = (div_q == 5'h0);
  wire half_tick = (div_q == HALF_CYCLES);
  wire bit_en    = rate_select || !div_q[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 5'h0;
    end else begin
      div_q <= (div_q == BYTE_CYCLES - 5'h1) ? 5'h0 : div_q + 5'h1;
    end
  end

  // character source, idles on comma when the fifo runs dry
  wire [LANE_W-1:0] head0 = fifo_valid ? fifo_data[LANE_W-1:0] : K28_5_POS;
  wire [LANE_W-1:0] head1 = fifo_valid ? fifo_data[WORD_W-1:LANE_W] : K28_5_POS;
  wire [LANE_W-1:0] lane0_d = comma_force_n ? head0 : K28_5_POS;
  wire pop_pair = byte_tick && !alt_mode && fifo_valid;
  wire pop_alt  = half_tick && alt_mode && alt_take_q;
  wire pop      = pop_pair || pop_alt;

  // input latch; characters pass unchanged, already encoded by sender
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane0_q    <= K28_5_POS;
      lane1_q    <= K28_5_POS;
      alt_take_q <= 1'b0;
    end else begin
      if (byte_tick) lane0_q <= lane0_d;
      if (byte_tick && !alt_mode) lane1_q <= head1;
      if (byte_tick) alt_take_q <= alt_mode && fifo_valid;
      if (half_tick && alt_mode) begin
        lane1_q <= alt_take_q ? head1 : K28_5_POS;
      end
    end
  end

  // frame shifter, lane 0 bit 0 leaves first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= {K28_5_POS, K28_5_POS};
    end else if (byte_tick) begin
      shift_q <= {lane1_q, lane0_q};
    end else if (bit_en) begin
      shift_q <= {1'b0, shift_q[WORD_W-1:1]};
    end
  end

  wire ser_bit = shift_q[0];

  // output routing, idle low when off
  wire [2:0] en_d      = route_enables(route_code);
  wire       laser_src = (route_code == ROUTE_SI_LASER) ? ext_serial_in : ser_bit;
  wire       loop_src  = (route_code == ROUTE_SI_LOOP) ? ext_serial_in : ser_bit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q    <= 3'h0;
      cable_q <= 1'b0;
      laser_q <= 1'b0;
      loop_q  <= 1'b0;
    end else begin
      en_q    <= en_d;
      cable_q <= en_d[2] && ser_bit;
      laser_q <= en_d[1] && laser_src;
      loop_q  <= en_d[0] && loop_src;
    end
  end

  assign cable_serial_out    = cable_q;
  assign laser_serial_out    = laser_q;
  assign loopback_serial_out = loop_q;
  assign cable_enable        = en_q[2];
  assign laser_enable        = en_q[1];
  assign loopback_enable     = en_q[0];

  // transmit buffer
  fc_tx_fifo #(
    .W (WORD_W),
    .D (DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[WORD_W-1:0]),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data),
    .count     (fifo_count)
  );

  // checks on capture, and on the forced comma loading into the shifter
  lane0_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick && comma_force_n && fifo_valid |=> lane0_q == $past(fifo_data[9:0]))
    else $error("lane 0 not captured at byte tick");
  comma_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick && !comma_force_n |=> lane0_q == K28_5_POS)
    else $error("forced comma missing or wrong form");
  comma_sent_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick && !comma_force_n ##20 1'b1 |=> shift_q[9:0] == K28_5_POS)
    else $error("comma not loaded into shifter");
  pair_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick && rate_select && !alternating_capture_select && fifo_valid
    |=> lane1_q == $past(fifo_data[19:10]) && lane0_q[9:0] == $past(lane0_d))
    else $error("lanes not captured together");
  alt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick && alt_mode && $stable(ctrl_q) |=> $stable(lane1_q))
    else $error("lane 1 moved at rising edge in alternating mode");
  alt_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick && alt_mode && fifo_valid && !pop ##10 half_tick && alt_mode
    |=> lane1_q == $past(head1, 1))
    else $error("lane 1 not taken half a cycle later");
  // checks on the shifter
  load_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick |=> shift_q == $past({lane1_q, lane0_q}))
    else $error("shifter not loaded at byte tick");
  fast_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
    rate_select && !byte_tick |=> shift_q == {1'b0, $past(shift_q[19:1])})
    else $error("high rate shift missed");
  slow_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rate_select && !byte_tick && div_q[0] |=> $stable(shift_q))
    else $error("low rate shifted too fast");
  // checks on routing, then the low rate shift step
  route_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    route_code == 3'h0 |=> laser_enable && !cable_enable && !loopback_enable
      && laser_serial_out == $past(ser_bit))
    else $error("code 0 routing wrong");
  route_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    route_code == 3'h6 |=> cable_enable && laser_enable && !loopback_enable
      && laser_serial_out == $past(ext_serial_in))
    else $error("code 6 routing wrong");
  route_both_a: assert property (@(posedge pclk) disable iff (!presetn)
    route_code == 3'h3 |=> cable_enable && loopback_enable && !laser_enable
      && loopback_serial_out == $past(ser_bit))
    else $error("code 3 routing wrong");
  route_five_a: assert property (@(posedge pclk) disable iff (!presetn)
    route_code == 3'h5 |=> !cable_enable && laser_enable && loopback_enable)
    else $error("code 5 routing wrong");
  idle_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!cable_enable |-> !cable_serial_out) and (!laser_enable |-> !laser_serial_out)
      and (!loopback_enable |-> !loopback_serial_out))
    else $error("disabled output not idle");
  route_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    route_code == 3'h7 |=> loopback_serial_out == $past(ext_serial_in) && cable_enable)
    else $error("code 7 routing wrong");
  route_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    route_code == 3'h1 |=> loopback_enable && !cable_enable && !laser_enable
      && loopback_serial_out == $past(ser_bit))
    else $error("code 1 routing wrong");
  route_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    route_code == 3'h2 |=> cable_enable && laser_enable && !loopback_enable
      && laser_serial_out == $past(ser_bit))
    else $error("code 2 routing wrong");
  route_four_a: assert property (@(posedge pclk) disable iff (!presetn)
    route_code == 3'h4 |=> cable_enable && !laser_enable && !loopback_enable
      && cable_serial_out == $past(ser_bit))
    else $error("code 4 routing wrong");
  slow_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rate_select && !byte_tick && !div_q[0] |=> shift_q == {1'b0, $past(shift_q[19:1])})
    else $error("low rate shift missed");
  // checks on the byte timer
  byte_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick |-> ##20 byte_tick)
    else $error("byte period not twenty cycles");
  half_point_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_tick |-> ##10 half_tick)
    else $error("half point not mid period");
endmodule

/* fc_link_sink.sv */
`timescale 1ns/10ps

module fc_link_sink (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // serial stream from the block
  input  wire logic        serial_in,
  // external serial pattern into the block
  output logic             ext_out,
  // last 20 line bits, first received bit in bit 0
  output logic [19:0]      word
);
  logic [19:0] word_q;
  logic [7:0]  lfsr_q;

  // collect line bits and step the external pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 20'h00000;
      lfsr_q <= 8'h5a;
    end else begin
      word_q <= {serial_in, word_q[19:1]};
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  // outputs: free-running pattern so a stale copy shows up
  assign ext_out = lfsr_q[0];
  assign word    = word_q;
endmodule

/* test_fc_tx_serializer_front_end.sv */
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end

module test_fc_tx_serializer_front_end
  import fc_tx_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, ext_serial_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, refused, found, e_prev;
  logic        cable_serial_out, laser_serial_out, loopback_serial_out;
  logic        cable_enable, laser_enable, loopback_enable;
  logic [19:0] sink_word, w1, w2;
  logic [2:0]  en_tab [8] = '{3'h2, 3'h1, 3'h6, 3'h5, 3'h4, 3'h3, 3'h6, 3'h5};
  logic [5:0]  mode_ctrl [4] = '{6'h15, 6'h17, 6'h11, 6'h14};
  int          fails, checks_done;
  integer      seed;

  fc_tx_serializer_front_end #(.DEPTH(FIFO_DEPTH)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_serial_in(ext_serial_in),
    .cable_serial_out(cable_serial_out), .laser_serial_out(laser_serial_out),
    .loopback_serial_out(loopback_serial_out), .cable_enable(cable_enable),
    .laser_enable(laser_enable), .loopback_enable(loopback_enable));

  fc_link_sink u_sink (.pclk(pclk), .presetn(presetn), .serial_in(cable_serial_out),
    .ext_out(ext_serial_in), .word(sink_word));

  // 125 MHz clock
  always #4 pclk = ~pclk;

  task automatic conclude;
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      conclude;
    end else begin
      if (n > 1) refused = 1'b1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // low rate line pattern: each lane 0 bit held for two pclk
  function automatic logic [19:0] dbl(input logic [9:0] l);
    logic [19:0] r;
    for (int i = 0; i < 20; i++) r[i] = l[i/2];
    return r;
  endfunction

  function automatic logic [19:0] expect_word(input int m, input logic [19:0] w);
    case (m)
      2: return {w[19:10], K28_5_POS};
      3: return dbl(w[9:0]);
      default: return w;
    endcase
  endfunction

  // look for a word on the cable line within a bounded time
  task automatic wait_word(input logic [19:0] e);
    found = 1'b0;
    for (int n = 0; n < 300 && !found; n++) begin
      @(posedge pclk);
      if (sink_word === e) found = 1'b1;
    end
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; fails = 0; checks_done = 0; seed = 58141;
    refused = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CTRL_OFF, 32'h0);
    `CHK("ctrl reset", 32'h00000004, rd)
    apb(0, STATUS_OFF, 32'h0);
    `CHK("status reset", 32'h00000100, rd)
    `CHK("enables reset", 3'h2, {cable_enable, laser_enable, loopback_enable})
    apb(0, 8'h0c, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    // every route code: enables, idle level; laser source for codes 2 and 6, loopback source for code 7
    for (int c = 0; c < 8; c++) begin
      apb(1, CTRL_OFF, {26'h0, c[2:0], 3'h5});
      repeat (3) @(posedge pclk);
      `CHK("route enables", en_tab[c], {cable_enable, laser_enable, loopback_enable})
      e_prev = ext_serial_in;
      for (int k = 0; k < 8; k++) begin
        @(posedge pclk);
        if (!cable_enable) `CHK("cable idle", 1'b0, cable_serial_out)
        if (!laser_enable) `CHK("laser idle", 1'b0, laser_serial_out)
        if (!loopback_enable) `CHK("loop idle", 1'b0, loopback_serial_out)
        if (c == 2) `CHK("laser internal", cable_serial_out, laser_serial_out)
        if (c == 6) `CHK("laser ext", e_prev, laser_serial_out)
        if (c == 7) `CHK("loop ext", e_prev, loopback_serial_out)
        e_prev = ext_serial_in;
      end
    end
    // rates, alternation and comma force with two back-to-back words
    for (int m = 0; m < 4; m++) begin
      apb(1, CTRL_OFF, {26'h0, mode_ctrl[m]});
      for (int r = 0; r < 2; r++) begin
        w1 = 20'($random(seed));
        w2 = 20'($random(seed));
        apb(1, TXDATA_OFF, {12'h0, w1});
        apb(1, TXDATA_OFF, {12'h0, w2});
        wait_word(expect_word(m, w1));
        `CHK("first word", 1'b1, found)
        wait_word(expect_word(m, w2));
        `CHK("second word", 1'b1, found)
      end
    end
    // fill the fifo until refused, then let it drain empty
    apb(1, CTRL_OFF, 32'h00000015);
    refused = 1'b0;
    for (int i = 0; i < 48; i++) apb(1, TXDATA_OFF, 32'($random(seed)));
    `CHK("fifo refused", 1'b1, refused)
    repeat (900) @(posedge pclk);
    apb(0, STATUS_OFF, 32'h0);
    `CHK("fifo drained", 32'h00000100, rd)
    conclude;
  end
endmodule
